// ---- rtl/uhps_defines.svh ----
// constants for the host pipe status block
`ifndef UHPS_DEFINES_SVH
`define UHPS_DEFINES_SVH
// register offsets (byte addresses, 8-bit bus offsets as printed)
`define UHPS_OFS_EXT 5'h08
`define UHPS_OFS_BK0 5'h0A
`define UHPS_OFS_CTRL 5'h0C
`define UHPS_OFS_PST0 5'h0E
`define UHPS_OFS_BK1 5'h1A
`define UHPS_OFS_PST1 5'h1E
`define UHPS_OFS_IFLAG 5'h10
`define UHPS_OFS_IMASK 5'h12
`define UHPS_OFS_CMD 5'h14
// pipe control fields
`define UHPS_LIM_HI 15
`define UHPS_LIM_LO 12
`define UHPS_EP_HI 11
`define UHPS_EP_LO 8
`define UHPS_ADR_HI 6
`define UHPS_ADR_LO 0
// pipe status fields
`define UHPS_CNT_HI 7
`define UHPS_CNT_LO 5
`define UHPS_CRC16 4
`define UHPS_TOUT 3
`define UHPS_PID 2
`define UHPS_DPID 1
`define UHPS_TGL 0
// bank status fields
`define UHPS_BK_FLOW 1
`define UHPS_BK_CRC 0
// interrupt flag bits
`define UHPS_IRQ_ERR 0
`define UHPS_IRQ_FLOW 1
`define UHPS_IRQ_FRZ 2
`define UHPS_IRQ_W 3
// command register bits
`define UHPS_CMD_UNFRZ 0
`define UHPS_CMD_TOK 1
// reset value and error counter constants
`define UHPS_RST16 16'h0000
`define UHPS_CNT_ONE 3'h1
`define UHPS_CNT_MAX 3'h7
`endif

// ---- rtl/uhps_pkg.sv ----
// types for the host pipe status block
package uhps_pkg;
    // one transaction outcome reported by the link engine
    typedef struct packed {
        logic valid;
        logic bank;
        logic iso;
        logic dir_in;
        logic nak;
        logic overrun;
        logic underflow;
        logic crc16;
        logic timeout;
        logic pid_err;
        logic dpid_err;
        logic toggle_err;
    } uhps_evt_t;
    // target presented to the link engine
    typedef struct packed {
        logic [6:0] dev_addr;
        logic [3:0] ep_num;
        logic [3:0] subtype;
        logic frozen;
    } uhps_tgt_t;
    // freeze state
    typedef enum logic [0:0] {
        UHPS_RUN = 1'b0,
        UHPS_FRZ = 1'b1
    } uhps_state_t;
endpackage

// ---- rtl/uhps_bank.sv ----
// sticky flag pair for one bank
`timescale 1ns/1ps
`include "uhps_defines.svh"
module uhps_bank
    import uhps_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // event
    input wire uhps_evt_t evt,
    input wire logic sel,
    // software write
    input wire logic wr_en,
    input wire logic [1:0] wr_data,
    // state
    output logic [1:0] flags_ff
);
    logic set_flow;
    logic set_crc;
    logic [1:0] nxt_flags;
    // nak on non-iso, overrun on iso in, underflow on iso out
    assign set_flow = sel & evt.valid & ((~evt.iso & evt.nak) |
        (evt.iso & evt.dir_in & evt.overrun) |
        (evt.iso & ~evt.dir_in & evt.underflow));
    assign set_crc = sel & evt.valid & evt.iso & evt.dir_in &
        evt.crc16;
    // set wins over software write
    assign nxt_flags[`UHPS_BK_FLOW] = set_flow |
        (wr_en ? wr_data[`UHPS_BK_FLOW] : flags_ff[`UHPS_BK_FLOW]);
    assign nxt_flags[`UHPS_BK_CRC] = set_crc |
        (wr_en ? wr_data[`UHPS_BK_CRC] : flags_ff[`UHPS_BK_CRC]);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_ff <= 2'h0;
        else
            flags_ff <= nxt_flags;
    end
    chk_flow_set: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        set_flow |=> flags_ff[`UHPS_BK_FLOW])
        else $error("bank flow flag not set");
    chk_crc_set: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        set_crc |=> flags_ff[`UHPS_BK_CRC])
        else $error("bank crc flag not set");
endmodule

// ---- rtl/uhps_ctrl.sv ----
// host pipe targeting and error status registers
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "uhps_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - the extended-token subtype field is sent with the extension token.
// - a nak on a non-iso transfer sets that bank's flow error flag.
// - iso in overrun or iso out underflow sets the bank flow error flag.
// - a crc error on an iso in bank sets that bank's crc error flag.
// - the pipe freezes once the error count reaches a nonzero error limit.
// - transactions go to the endpoint held in the endpoint field.
// - transactions go to the device address held in the control field.
// - a read-only 3-bit counter keeps the number of erroring transactions, saturating at seven.
// - a crc16 error on in data sets the data crc error flag.
// - a response timeout sets the timeout error flag.
// - a failed pid check sets the pid error flag.
// - an invalid data pid sets the data pid error flag.
// - a data toggle mismatch sets the toggle error flag.
module uhps_ctrl
    import uhps_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_ff,
    // link engine side
    input wire uhps_evt_t evt,
    output uhps_tgt_t tgt_ff,
    output logic ext_token_ff,
    // interrupt
    output logic irq_ff
);
    //////////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
        hit = (a == o);
    endfunction

    logic wr_ext;
    logic wr_bk0;
    logic wr_bk1;
    logic wr_ctrl;
    logic wr_pst0;
    logic wr_pst1;
    logic wr_iflag;
    logic wr_imask;
    logic wr_cmd;
    assign wr_ext = reg_wr & hit(reg_addr, `UHPS_OFS_EXT);
    assign wr_bk0 = reg_wr & hit(reg_addr, `UHPS_OFS_BK0);
    assign wr_bk1 = reg_wr & hit(reg_addr, `UHPS_OFS_BK1);
    assign wr_ctrl = reg_wr & hit(reg_addr, `UHPS_OFS_CTRL);
    assign wr_pst0 = reg_wr & hit(reg_addr, `UHPS_OFS_PST0);
    assign wr_pst1 = reg_wr & hit(reg_addr, `UHPS_OFS_PST1);
    assign wr_iflag = reg_wr & hit(reg_addr, `UHPS_OFS_IFLAG);
    assign wr_imask = reg_wr & hit(reg_addr, `UHPS_OFS_IMASK);
    assign wr_cmd = reg_wr & hit(reg_addr, `UHPS_OFS_CMD);

    //////////////////////////////////////////////////////////////////////////
    // control register and extended token subtype
    logic [15:0] ctrl_ff;
    logic [3:0] subtype_ff;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= `UHPS_RST16;
            subtype_ff <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= reg_wdata;
            if (wr_ext)
                subtype_ff <= reg_wdata[3:0];
        end
    end

    logic [3:0] err_limit;
    assign err_limit = ctrl_ff[`UHPS_LIM_HI:`UHPS_LIM_LO];

    //////////////////////////////////////////////////////////////////////////
    // bank flags
    logic [1:0] bk0_flags;
    logic [1:0] bk1_flags;
    uhps_bank u_bank0 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .evt(evt),
        .sel(~evt.bank),
        .wr_en(wr_bk0),
        .wr_data(reg_wdata[1:0]),
        .flags_ff(bk0_flags)
    );
    uhps_bank u_bank1 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .evt(evt),
        .sel(evt.bank),
        .wr_en(wr_bk1),
        .wr_data(reg_wdata[1:0]),
        .flags_ff(bk1_flags)
    );

    //////////////////////////////////////////////////////////////////////////
    // pipe error flags, set per transaction
    logic [4:0] err_set;
    logic any_err;
    assign err_set[`UHPS_CRC16] = evt.valid & evt.dir_in & evt.crc16;
    assign err_set[`UHPS_TOUT] = evt.valid & evt.timeout;
    assign err_set[`UHPS_PID] = evt.valid & evt.pid_err;
    assign err_set[`UHPS_DPID] = evt.valid & evt.dpid_err;
    assign err_set[`UHPS_TGL] = evt.valid & evt.toggle_err;
    assign any_err = |err_set;

    // writable low three flags; crc16 and timeout are read only
    logic wr_pst;
    logic [4:0] pst_ff;
    logic [4:0] nxt_pst;
    assign wr_pst = wr_pst0 | wr_pst1;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_pst
            if (gi <= `UHPS_PID)
            begin : g_rw
                assign nxt_pst[gi] = err_set[gi] |
                    (wr_pst ? reg_wdata[gi] : pst_ff[gi]);
            end
            else
            begin : g_ro
                assign nxt_pst[gi] = err_set[gi] | pst_ff[gi];
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // error counter and freeze
    uhps_state_t state_ff;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic unfreeze;
    logic freeze_now;
    logic tok_cmd;
    // command bits; both act only in the cycle of the write
    assign unfreeze = wr_cmd & reg_wdata[`UHPS_CMD_UNFRZ];
    assign tok_cmd = wr_cmd & reg_wdata[`UHPS_CMD_TOK];
    // saturating count of erroring transactions
    assign nxt_cnt = unfreeze ? 3'h0 :
        (any_err && cnt_ff != `UHPS_CNT_MAX) ?
        cnt_ff + `UHPS_CNT_ONE : cnt_ff;
    // a zero limit never freezes; the count saturates at seven, so a
    // limit above seven is never reached either
    assign freeze_now = (err_limit != 4'h0) &&
        ({1'b0, nxt_cnt} >= err_limit);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pst_ff <= 5'h00;
            cnt_ff <= 3'h0;
            state_ff <= UHPS_RUN;
        end
        else
        begin
            pst_ff <= nxt_pst;
            cnt_ff <= nxt_cnt;
            case (state_ff)
                UHPS_RUN: if (freeze_now) state_ff <= UHPS_FRZ;
                UHPS_FRZ: if (unfreeze) state_ff <= UHPS_RUN;
                default: state_ff <= UHPS_RUN;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // target toward the link engine
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tgt_ff <= '0;
            ext_token_ff <= 1'b0;
        end
        else
        begin
            tgt_ff.dev_addr <= ctrl_ff[`UHPS_ADR_HI:`UHPS_ADR_LO];
            tgt_ff.ep_num <= ctrl_ff[`UHPS_EP_HI:`UHPS_EP_LO];
            tgt_ff.subtype <= subtype_ff;
            tgt_ff.frozen <= (state_ff == UHPS_FRZ);
            ext_token_ff <= tok_cmd;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt flags, write one to clear, set wins
    logic [`UHPS_IRQ_W-1:0] iev;
    logic [`UHPS_IRQ_W-1:0] iflag_ff;
    logic [`UHPS_IRQ_W-1:0] imask_ff;
    logic flow_evt;
    // flow events of either bank raise the flow flag, crc events do not
    assign flow_evt = evt.valid & ((~evt.iso & evt.nak) |
        (evt.iso & evt.dir_in & evt.overrun) |
        (evt.iso & ~evt.dir_in & evt.underflow));
    assign iev[`UHPS_IRQ_ERR] = any_err;
    assign iev[`UHPS_IRQ_FLOW] = flow_evt;
    assign iev[`UHPS_IRQ_FRZ] = (state_ff == UHPS_RUN) & freeze_now;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            iflag_ff <= 3'h0;
            imask_ff <= 3'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            iflag_ff <= iev | (iflag_ff &
                ~(wr_iflag ? reg_wdata[`UHPS_IRQ_W-1:0] : 3'h0));
            if (wr_imask)
                imask_ff <= reg_wdata[`UHPS_IRQ_W-1:0];
            irq_ff <= |(iflag_ff & imask_ff);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux; both pipe status offsets show the one pipe and
    // unmapped offsets read as zero
    logic [15:0] pst_word;
    logic [15:0] rd_mux;
    assign pst_word = {8'h00, cnt_ff, pst_ff};
    assign rd_mux =
        hit(reg_addr, `UHPS_OFS_EXT) ? {12'h000, subtype_ff} :
        hit(reg_addr, `UHPS_OFS_BK0) ? {14'h0000, bk0_flags} :
        hit(reg_addr, `UHPS_OFS_BK1) ? {14'h0000, bk1_flags} :
        hit(reg_addr, `UHPS_OFS_CTRL) ? ctrl_ff :
        hit(reg_addr, `UHPS_OFS_PST0) ? pst_word :
        hit(reg_addr, `UHPS_OFS_PST1) ? pst_word :
        hit(reg_addr, `UHPS_OFS_IFLAG) ? {13'h0000, iflag_ff} :
        hit(reg_addr, `UHPS_OFS_IMASK) ? {13'h0000, imask_ff} :
        hit(reg_addr, `UHPS_OFS_CMD) ? {15'h0000, tgt_ff.frozen} :
        `UHPS_RST16;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_ff <= `UHPS_RST16;
        else if (reg_rd)
            reg_rdata_ff <= rd_mux;
        else
            reg_rdata_ff <= `UHPS_RST16;
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_err_at_limit;
        (err_limit != 4'h0) && ({1'b0, nxt_cnt} >= err_limit);
    endsequence
    sequence s_token_cmd;
        tok_cmd;
    endsequence
    // freeze reaches the state and then the link engine
    chk_freeze_limit: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_err_at_limit |=> (state_ff == UHPS_FRZ) ##1 tgt_ff.frozen)
        else $error("pipe not frozen at limit");
    chk_freeze_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (state_ff == UHPS_FRZ && !unfreeze) |=> state_ff == UHPS_FRZ)
        else $error("pipe left freeze on its own");
    chk_zero_limit: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (state_ff == UHPS_RUN && err_limit == 4'h0) |=> state_ff == UHPS_RUN)
        else $error("pipe froze with zero limit");
    chk_frozen_out: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        tgt_ff.frozen == $past(state_ff == UHPS_FRZ))
        else $error("frozen output does not follow state");
    // count steps, saturates, holds and clears
    chk_cnt_step: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (any_err && !unfreeze && cnt_ff != 3'h7)
        |=> cnt_ff == $past(cnt_ff) + 3'h1)
        else $error("error count did not step");
    chk_cnt_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!any_err && !unfreeze) |=> $stable(cnt_ff))
        else $error("error count changed without error");
    chk_cnt_sat: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (cnt_ff == `UHPS_CNT_MAX && !unfreeze) |=> cnt_ff == `UHPS_CNT_MAX)
        else $error("error count left saturation");
    chk_cnt_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        unfreeze |=> cnt_ff == 3'h0 && state_ff == UHPS_RUN)
        else $error("release did not clear the count");
    chk_err_counted: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        any_err |=> (pst_ff != 5'h00))
        else $error("counted error left no flag");
    // pipe flags, set on the cycle after their event
    chk_crc16_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        err_set[`UHPS_CRC16] |=> pst_ff[`UHPS_CRC16])
        else $error("crc16 flag not set");
    chk_tout_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        err_set[`UHPS_TOUT] |=> pst_ff[`UHPS_TOUT])
        else $error("timeout flag not set");
    chk_pid_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        err_set[`UHPS_PID] |=> pst_ff[`UHPS_PID])
        else $error("pid flag not set");
    chk_dpid_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        err_set[`UHPS_DPID] |=> pst_ff[`UHPS_DPID])
        else $error("data pid flag not set");
    chk_tgl_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        err_set[`UHPS_TGL] |=> pst_ff[`UHPS_TGL])
        else $error("toggle flag not set");
    chk_ro_status: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_pst && !err_set[`UHPS_CRC16] && !err_set[`UHPS_TOUT])
        |=> $stable(pst_ff[`UHPS_CRC16:`UHPS_TOUT]))
        else $error("read-only status bits took a write");
    chk_flow_irq: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        flow_evt |=> iflag_ff[`UHPS_IRQ_FLOW])
        else $error("flow event raised no flag");
    // targeting and token toward the link engine
    chk_target_addr: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl |=> ##1 tgt_ff.dev_addr == $past(reg_wdata[6:0], 2)
        && tgt_ff.ep_num == $past(reg_wdata[11:8], 2))
        else $error("target not taken from control");
    chk_subtype_out: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_ext |=> ##1 tgt_ff.subtype == $past(reg_wdata[3:0], 2))
        else $error("subtype not presented");
    chk_token_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_token_cmd |=> ext_token_ff)
        else $error("extension token not pulsed");
    chk_token_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !tok_cmd |=> !ext_token_ff)
        else $error("extension token without command");
endmodule

// ---- verification/uhps_link_model.sv ----
// link engine stand-in that reports transaction outcomes to the block
`timescale 1ns/1ps
module uhps_link_model
    import uhps_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // request from the bench
    input wire logic req,
    input wire uhps_evt_t req_evt,
    // outcome towards the block
    output uhps_evt_t evt
);
    logic [10:0] idle_ff;

    // one valid cycle per request; between them the fields keep moving
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evt <= '0;
            idle_ff <= 11'h2A5;
        end
        else
        begin
            idle_ff <= ~idle_ff;
            evt <= req ? req_evt : {1'b0, idle_ff};
        end
    end
endmodule

// ---- verification/tb_uhps_ctrl.sv ----
// self-checking bench for the host pipe status block
`timescale 1ns/1ps
`include "uhps_defines.svh"
module tb_uhps_ctrl
    import uhps_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata_ff;
    logic req = 1'b0;
    uhps_evt_t req_evt = '0;
    uhps_evt_t evt;
    uhps_tgt_t tgt_ff;
    logic ext_token_ff;
    logic irq_ff;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] rnd = 32'd75991;
    int cnt = 0, pst = 0, frz = 0, lim = 0, ifl = 0, msk = 0;
    int bk[2] = '{0, 0};
    logic [11:0] ev[13] = '{12'h980, 12'hC80, 12'hB40, 12'hE20, 12'hA40,
        12'hF10, 12'h910, 12'h810, 12'h808, 12'h804, 12'h802, 12'h801,
        12'hB80};

    ////////////////////////////////////////////////////////////////////////
    // clock, design and far side
    always #5 sys_clk = ~sys_clk;

    uhps_ctrl DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .evt(evt), .tgt_ff(tgt_ff),
        .ext_token_ff(ext_token_ff), .irq_ff(irq_ff));

    uhps_link_model u_link (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
        .req_evt(req_evt), .evt(evt));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function logic [31:0] lfsr_step(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_ff;
    endtask

    // reference behaviour of one reported transaction
    task send(input uhps_evt_t e);
        logic perr;
        logic flow;
        @(posedge sys_clk);
        req <= 1'b1;
        req_evt <= e;
        @(posedge sys_clk);
        req <= 1'b0;
        perr = (e.crc16 & e.dir_in) | e.timeout | e.pid_err | e.dpid_err
            | e.toggle_err;
        flow = e.iso ? (e.dir_in ? e.overrun : e.underflow) : e.nak;
        pst |= {e.crc16 & e.dir_in, e.timeout, e.pid_err, e.dpid_err,
            e.toggle_err};
        bk[e.bank] |= {flow, e.iso & e.dir_in & e.crc16};
        if (flow)
            ifl |= 2;
        if (perr)
        begin
            ifl |= 1;
            if (cnt < 7)
                cnt++;
            if (lim != 0 && cnt == lim)
            begin
                frz = 1;
                ifl |= 4;
            end
        end
        repeat (4) @(posedge sys_clk);
    endtask

    task results;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial
    begin
        #100000;
        num_errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [15:0] d;
        logic [15:0] ctl;
        logic [3:0] st;
        int k;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(`UHPS_OFS_CTRL, d); chk(d, 16'h0000);
        rd(`UHPS_OFS_PST0, d); chk(d, 16'h0000);
        rd(5'h02, d); chk(d, 16'h0000);
        // targeting fields reach the link side
        rnd = lfsr_step(rnd);
        ctl = rnd[15:0];
        wr(`UHPS_OFS_CTRL, ctl);
        wr(5'h02, 16'hFFFF);
        rd(`UHPS_OFS_CTRL, d); chk(d, ctl);
        chk({9'h000, tgt_ff.dev_addr}, {9'h000, ctl[6:0]});
        chk({12'h000, tgt_ff.ep_num}, {12'h000, ctl[11:8]});
        // extension token carries the subtype
        for (k = 0; k < 3; k++)
        begin
            rnd = lfsr_step(rnd);
            st = rnd[3:0];
            wr(`UHPS_OFS_EXT, {12'h000, st});
            wr(`UHPS_OFS_CMD, 16'h0002);
            #1;
            repeat (6)
                if (ext_token_ff !== 1'b1)
                    @(posedge sys_clk) #1;
            chk({15'h0000, ext_token_ff}, 16'h0001);
            chk({12'h000, tgt_ff.subtype}, {12'h000, st});
            // the token request is a single-cycle pulse
            @(posedge sys_clk) #1;
            chk({15'h0000, ext_token_ff}, 16'h0000);
        end
        // only the low three status bits take a plain write
        wr(`UHPS_OFS_PST0, 16'hFFFF);
        rd(`UHPS_OFS_PST1, d); chk(d, 16'h0007);
        wr(`UHPS_OFS_PST0, 16'h0000);
        lim = 3;
        wr(`UHPS_OFS_CTRL, {4'h3, ctl[11:0]});
        // every kind of outcome, with the mask swapped between steps
        for (k = 0; k < 13; k++)
        begin
            msk = k[0] ? 1 : 6;
            wr(`UHPS_OFS_IMASK, 16'(msk));
            send(ev[k]);
            rd(`UHPS_OFS_BK0, d); chk(d, 16'(bk[0]));
            rd(`UHPS_OFS_BK1, d); chk(d, 16'(bk[1]));
            rd(k[0] ? `UHPS_OFS_PST0 : `UHPS_OFS_PST1, d);
            chk(d, 16'((cnt << 5) | pst));
            rd(`UHPS_OFS_CMD, d); chk({15'h0000, d[0]}, 16'(frz));
            chk({15'h0000, tgt_ff.frozen}, 16'(frz));
            chk({15'h0000, irq_ff}, 16'((ifl & msk) != 0));
            rd(`UHPS_OFS_IFLAG, d); chk(d, 16'(ifl));
            wr(`UHPS_OFS_IFLAG, 16'(ifl));
            ifl = 0;
            wr(`UHPS_OFS_BK0, 16'h0000);
            wr(`UHPS_OFS_BK1, 16'h0000);
            wr(`UHPS_OFS_PST0, 16'h0000);
            bk = '{0, 0};
            pst &= 24;
            if (frz != 0)
            begin
                wr(`UHPS_OFS_CMD, 16'h0001);
                cnt = 0;
                frz = 0;
            end
            chk({15'h0000, irq_ff}, 16'h0000);
        end
        results();
    end
endmodule
